// >>> hw/ssq_top.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "ssq_cfg.svh"
module ssq_top
  import ssq_pkg::*;
#(
  parameter int PRESCALE_UNIT = `SSQ_PRESCALE,
  parameter int OFFSET_MAX = 15
)(
  input wire logic aclk, // 200 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic arb_won, // Arbitration won
  input wire logic target_bsy, // Target answered selection
  input wire logic target_req, // Target request with phase
  input wire logic [2:0] bus_phase, // Msg, cd, io
  input wire logic byte_done, // One byte moved, pulse
  input wire logic [3:0] sync_offset_count, // Offset in use
  output logic arb_req, // Arbitrate for the bus
  output logic sel_out, // Drive selection
  output logic atn_out, // Drive attention
  output logic xfer_req, // Move a byte
  output logic int_out // Interrupt pending
);

  // ---------------------------------------------
  // Bus slave
  // ---------------------------------------------
  logic aw_got, w_got, aw_hit, w_hit, ar_hit, do_wr;
  logic next_bvalid, next_rvalid;
  logic [7:0] aw_q, wd_q, wa, wd;
  logic [5:0] w_idx, r_idx;
  logic w_ok, r_ok;

  assign aw_hit = s_axi_awvalid && s_axi_awready;
  assign w_hit = s_axi_wvalid && s_axi_wready;
  assign ar_hit = s_axi_arvalid && s_axi_arready;
  assign do_wr = (aw_got || aw_hit) && (w_got || w_hit);
  assign wa = aw_hit ? s_axi_awaddr : aw_q;
  assign wd = w_hit ? s_axi_wdata[7:0] : wd_q;
  assign w_idx = wa[7:2];
  assign r_idx = s_axi_araddr[7:2];
  assign next_bvalid = do_wr || (s_axi_bvalid && !s_axi_bready);
  assign next_rvalid = ar_hit || (s_axi_rvalid && !s_axi_rready);
  // Timeout shares its index with the cause register
  assign w_ok = w_idx == 6'(`SSQ_IDX_TIMEOUT)
    || w_idx == 6'(`SSQ_IDX_CLKF) || w_idx == 6'(`SSQ_IDX_CMD)
    || w_idx == 6'(`SSQ_IDX_CMDLEN);
  assign r_ok = r_idx == 6'(`SSQ_IDX_TIMEOUT)
    || r_idx == 6'(`SSQ_IDX_STEP) || r_idx == 6'(`SSQ_IDX_CLKF)
    || r_idx == 6'(`SSQ_IDX_CMD) || r_idx == 6'(`SSQ_IDX_CMDLEN);

  // Address and data may come in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 8'h00;
    end
    else
    begin
      aw_got <= (aw_got || aw_hit) && !do_wr;
      w_got <= (w_got || w_hit) && !do_wr;
      if (aw_hit)
        aw_q <= s_axi_awaddr;
      if (w_hit)
        wd_q <= s_axi_wdata[7:0];
    end
  end

  // Ready held low while a response waits, one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSQ_OKAY;
    end
    else
    begin
      s_axi_awready <= !((aw_got || aw_hit) && !do_wr) && !next_bvalid;
      s_axi_wready <= !((w_got || w_hit) && !do_wr) && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_wr)
        s_axi_bresp <= w_ok ? `SSQ_OKAY : `SSQ_SLVERR;
    end
  end

  // ---------------------------------------------
  // Software registers
  // ---------------------------------------------
  logic [7:0] timeout_value;
  logic [2:0] clock_factor;
  logic [3:0] cmd_len;
  logic start, soft_rst, wr_en;
  ssq_kind_t kind;

  assign wr_en = do_wr && s_axi_wstrb[0];

  // Timeout survives soft reset, cleared by hardware reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timeout_value <= 8'h00;
      clock_factor <= `SSQ_RST_CLKF;
      cmd_len <= `SSQ_RST_CMDLEN;
    end
    else if (wr_en)
    begin
      if (w_idx == 6'(`SSQ_IDX_TIMEOUT))
        timeout_value <= wd;
      if (w_idx == 6'(`SSQ_IDX_CLKF))
        clock_factor <= wd[2:0];
      if (w_idx == 6'(`SSQ_IDX_CMDLEN))
        cmd_len <= wd[3:0];
    end
  end

  // Command writes start a sequence or soft reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start <= 1'b0;
      soft_rst <= 1'b0;
      kind <= SSQ_NOATN;
    end
    else
    begin
      start <= 1'b0;
      soft_rst <= 1'b0;
      if (wr_en && w_idx == 6'(`SSQ_IDX_CMD))
      begin
        soft_rst <= wd[`SSQ_CMD_SRST];
        start <= !wd[`SSQ_CMD_SRST];
        kind <= ssq_kind_t'(wd[1:0]);
      end
    end
  end

  // ---------------------------------------------
  // Selection timer
  // ---------------------------------------------
  logic [15:0] pre_cnt, pre_lim;
  logic [7:0] tmo_cnt;
  logic tick, sel_timeout;
  ssq_state_t state;

  // A zero factor would stop the timer, so treat it as one
  assign pre_lim = 16'(PRESCALE_UNIT) *
    ((clock_factor == 3'h0) ? 16'h0001 : 16'(clock_factor));
  assign tick = state == SSQ_SEL && pre_cnt == pre_lim - 16'h0001;
  assign sel_timeout = tick && tmo_cnt <= 8'h01;

  // Prescaler and down-counter restart at each selection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_cnt <= 16'h0000;
      tmo_cnt <= 8'h00;
    end
    else if (state != SSQ_SEL)
    begin
      pre_cnt <= 16'h0000;
      tmo_cnt <= timeout_value;
    end
    else
    begin
      pre_cnt <= tick ? 16'h0000 : pre_cnt + 16'h0001;
      if (tick)
        tmo_cnt <= tmo_cnt - 8'h01;
    end
  end

  // ---------------------------------------------
  // Selection sequencer
  // ---------------------------------------------
  logic [2:0] step_code;
  logic [7:0] interrupt_cause;
  logic [1:0] msg_cnt;
  logic [3:0] cmd_cnt;
  logic cause_rd, sof_n;

  assign cause_rd = ar_hit && r_idx == 6'(`SSQ_IDX_TIMEOUT);
  assign sof_n = 32'(sync_offset_count) != OFFSET_MAX;

  // Reads clear first so a same-cycle event still sets
  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_rst)
    begin
      state <= SSQ_IDLE;
      step_code <= 3'h0;
      interrupt_cause <= 8'h00;
      int_out <= 1'b0;
      arb_req <= 1'b0;
      sel_out <= 1'b0;
      atn_out <= 1'b0;
      xfer_req <= 1'b0;
      msg_cnt <= 2'h0;
      cmd_cnt <= 4'h0;
    end
    else
    begin
      if (cause_rd && int_out)
      begin
        step_code <= 3'h0;
        interrupt_cause <= 8'h00;
      end
      if (cause_rd)
        int_out <= 1'b0;
      unique case (state)
        SSQ_IDLE:
          if (start)
          begin
            state <= SSQ_ARB;
            arb_req <= 1'b1;
            msg_cnt <= 2'h0;
            cmd_cnt <= 4'h0;
            atn_out <= 1'b0;
          end
        SSQ_ARB:
          if (arb_won)
          begin
            state <= SSQ_SEL;
            arb_req <= 1'b0;
            sel_out <= 1'b1;
            atn_out <= kind != SSQ_NOATN;
          end
        SSQ_SEL:
          if (target_bsy)
          begin
            sel_out <= 1'b0;
            if (kind == SSQ_NOATN)
            begin
              state <= SSQ_CMD_WAIT;
              step_code <= `SSQ_STEP_MSG;
            end
            else
            begin
              state <= SSQ_MSG_WAIT;
              step_code <= `SSQ_STEP_SEL;
            end
          end
          else if (sel_timeout)
          begin
            state <= SSQ_IDLE;
            sel_out <= 1'b0;
            atn_out <= 1'b0;
            step_code <= `SSQ_STEP_SEL;
            interrupt_cause <= `SSQ_CAUSE_DISC;
            int_out <= 1'b1;
          end
        SSQ_MSG_WAIT:
          if (target_req)
          begin
            if (bus_phase == `SSQ_PH_MSGOUT)
            begin
              state <= SSQ_MSG_XFER;
              xfer_req <= 1'b1;
            end
            else
            begin
              // Attention stays driven on this halt
              state <= SSQ_IDLE;
              step_code <= (msg_cnt == 2'h0) ?
                `SSQ_STEP_SEL : `SSQ_STEP_MSG;
              interrupt_cause <= `SSQ_CAUSE_DONE;
              int_out <= 1'b1;
            end
          end
        SSQ_MSG_XFER:
          if (byte_done)
          begin
            xfer_req <= 1'b0;
            msg_cnt <= msg_cnt + 2'h1;
            if (kind == SSQ_ATNSTOP)
            begin
              state <= SSQ_IDLE;
              step_code <= `SSQ_STEP_MSG;
              interrupt_cause <= `SSQ_CAUSE_DONE;
              int_out <= 1'b1;
            end
            else if (kind == SSQ_ATN
              || msg_cnt + 2'h1 == `SSQ_MSG3)
            begin
              state <= SSQ_CMD_WAIT;
              atn_out <= 1'b0;
              step_code <= `SSQ_STEP_MSG;
            end
            else
              state <= SSQ_MSG_WAIT;
          end
          else if (target_req && bus_phase != `SSQ_PH_MSGOUT)
          begin
            state <= SSQ_IDLE;
            xfer_req <= 1'b0;
            step_code <= `SSQ_STEP_MSG;
            interrupt_cause <= `SSQ_CAUSE_DONE;
            int_out <= 1'b1;
          end
        SSQ_CMD_WAIT:
          if (target_req)
          begin
            if (bus_phase == `SSQ_PH_CMD)
            begin
              state <= SSQ_CMD_XFER;
              xfer_req <= 1'b1;
              step_code <= `SSQ_STEP_CMD;
            end
            else
            begin
              state <= SSQ_IDLE;
              step_code <= `SSQ_STEP_MSG;
              interrupt_cause <= `SSQ_CAUSE_DONE;
              int_out <= 1'b1;
            end
          end
        SSQ_CMD_XFER:
          if (byte_done)
          begin
            cmd_cnt <= cmd_cnt + 4'h1;
            if (cmd_cnt + 4'h1 == cmd_len)
            begin
              state <= SSQ_IDLE;
              xfer_req <= 1'b0;
              step_code <= `SSQ_STEP_FULL;
              interrupt_cause <= `SSQ_CAUSE_DONE;
              int_out <= 1'b1;
            end
          end
          else if (target_req && bus_phase != `SSQ_PH_CMD)
          begin
            // Unsent command bytes are left to software
            state <= SSQ_IDLE;
            xfer_req <= 1'b0;
            step_code <= `SSQ_STEP_CMD;
            interrupt_cause <= `SSQ_CAUSE_DONE;
            int_out <= 1'b1;
          end
      endcase
    end
  end

  // ---------------------------------------------
  // Read port
  // ---------------------------------------------
  // Read data and answer one cycle after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SSQ_OKAY;
    end
    else
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_hit)
      begin
        s_axi_rresp <= r_ok ? `SSQ_OKAY : `SSQ_SLVERR;
        s_axi_rdata <= 32'h0000_0000;
        if (r_idx == 6'(`SSQ_IDX_TIMEOUT))
          s_axi_rdata[7:0] <= interrupt_cause;
        if (r_idx == 6'(`SSQ_IDX_STEP))
          s_axi_rdata[3:0] <= {sof_n, step_code};
        if (r_idx == 6'(`SSQ_IDX_CLKF))
          s_axi_rdata[2:0] <= clock_factor;
        if (r_idx == 6'(`SSQ_IDX_CMD))
          s_axi_rdata[3:0] <= {state != SSQ_IDLE, atn_out, kind};
        if (r_idx == 6'(`SSQ_IDX_CMDLEN))
          s_axi_rdata[3:0] <= cmd_len;
      end
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  chk_timeout_ends: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state == SSQ_SEL && sel_timeout && !target_bsy |=>
      state == SSQ_IDLE && step_code == 3'h0
      && interrupt_cause == 8'h20 && !sel_out)
    else $error("timeout did not disconnect");
  chk_tmo_reload: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state == SSQ_ARB && arb_won |=> tmo_cnt == $past(timeout_value))
    else $error("timer not loaded");
  chk_cause_clears: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cause_rd && int_out && state == SSQ_IDLE && !soft_rst
      |=> step_code == 3'h0 && !int_out)
    else $error("cause read did not clear");
  chk_full_done: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state == SSQ_CMD_XFER && byte_done && cmd_cnt + 4'h1 == cmd_len
      |=> step_code == 3'h4 && interrupt_cause == 8'h18 && int_out)
    else $error("full completion code wrong");
  chk_cmd_halt: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state == SSQ_CMD_XFER && !byte_done && target_req
      && bus_phase != 3'h2 |=> step_code == 3'h3 && !xfer_req)
    else $error("command halt code wrong");
  chk_no_cmd: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state == SSQ_CMD_WAIT && target_req && bus_phase != 3'h2
      |=> step_code == 3'h2 && state == SSQ_IDLE)
    else $error("missing command phase code wrong");
  chk_no_msgout: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state == SSQ_MSG_WAIT && msg_cnt == 2'h0 && target_req
      && bus_phase != 3'h6 |=> step_code == 3'h0 && atn_out)
    else $error("attention dropped on halt");
  chk_atn_release: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state == SSQ_MSG_XFER && byte_done && kind == SSQ_ATN
      |=> !atn_out ##0 state == SSQ_CMD_WAIT)
    else $error("attention not released");
  chk_stop_keeps: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state == SSQ_MSG_XFER && byte_done && kind == SSQ_ATNSTOP
      |=> atn_out && int_out && state == SSQ_IDLE)
    else $error("stop form lost attention");
  chk_sof_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_hit && r_idx == 6'h06 |=> s_axi_rdata[3]
      == ($past(sync_offset_count) != 4'hf) && s_axi_rdata[7:4] == 4'h0)
    else $error("offset flag wrong");

endmodule

// >>> inc/ssq_cfg.svh
`ifndef SSQ_CFG_SVH
`define SSQ_CFG_SVH
// Register indices; byte address is four times the index
`define SSQ_IDX_TIMEOUT 8'h05
`define SSQ_IDX_STEP 8'h06
`define SSQ_IDX_CLKF 8'h09
`define SSQ_IDX_CMD 8'h10
`define SSQ_IDX_CMDLEN 8'h11
// Field positions
`define SSQ_CMD_SRST 7
`define SSQ_STEP_SOF 3
// Reset values
`define SSQ_RST_CLKF 3'h2
`define SSQ_RST_CMDLEN 4'h6
// Interrupt cause codes
`define SSQ_CAUSE_DISC 8'h20
`define SSQ_CAUSE_DONE 8'h18
// Step codes
`define SSQ_STEP_SEL 3'h0
`define SSQ_STEP_MSG 3'h2
`define SSQ_STEP_CMD 3'h3
`define SSQ_STEP_FULL 3'h4
// Bus phases seen as msg/cd/io
`define SSQ_PH_MSGOUT 3'h6
`define SSQ_PH_CMD 3'h2
// Message bytes of the three-byte selection
`define SSQ_MSG3 2'h3
// Timing: prescale unit and standard wait
`define SSQ_PRESCALE 8192
`define SSQ_STD_WAIT_MS 250
// AXI responses
`define SSQ_OKAY 2'h0
`define SSQ_SLVERR 2'h2
`endif

// >>> inc/ssq_pkg.sv
package ssq_pkg;
  // Selection kinds
  typedef enum logic [1:0] {
    SSQ_NOATN, SSQ_ATN, SSQ_SELECT_THREE_MSG_BYTES, SSQ_ATNSTOP
  } ssq_kind_t;
  // Sequencer states
  typedef enum logic [2:0] {
    SSQ_IDLE, SSQ_ARB, SSQ_SEL, SSQ_MSG_WAIT, SSQ_MSG_XFER,
    SSQ_CMD_WAIT, SSQ_CMD_XFER
  } ssq_state_t;
endpackage

// >>> tb/ssq_far_end.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-end target on the shared bus
// ----------------------------------------
module ssq_far_end (
  input wire logic aclk, // Bench clock
  input wire logic aresetn, // Reset, active low
  input wire logic arb_req, // Device arbitrates
  input wire logic sel_out, // Device selects
  input wire logic xfer_req, // Device moves a byte
  input wire logic int_out, // Sequence ended
  input wire logic answer, // Answer the selection
  input wire logic [1:0] msg_n, // Message bytes to take
  input wire logic [3:0] cmd_n, // Command bytes to take
  input wire logic [1:0] lag, // Extra answer delay
  output logic arb_won, // Arbitration result
  output logic target_bsy, // Selection answer
  output logic target_req, // Byte request
  output logic [2:0] bus_phase, // Msg, cd, io
  output logic byte_done // One byte moved
);
  int i;
  int k;

  // One byte; phase lines scramble once released so stale values never help
  task automatic move_byte(input logic [2:0] ph);
    repeat (lag) @(posedge aclk);
    target_req <= 1'b1;
    bus_phase <= ph;
    @(posedge aclk);
    k = 0;
    while (!xfer_req && k < 40)
    begin
      @(posedge aclk);
      k++;
    end
    target_req <= 1'b0;
    bus_phase <= ~ph;
    byte_done <= 1'b1;
    @(posedge aclk);
    byte_done <= 1'b0;
  endtask

  // Serve one sequence; a short target forces a halt with a status phase
  initial
  begin
    arb_won = 1'b0;
    target_bsy = 1'b0;
    target_req = 1'b0;
    bus_phase = 3'h0;
    byte_done = 1'b0;
    forever
    begin
      @(posedge aclk);
      if (arb_req && aresetn)
      begin
        repeat (lag) @(posedge aclk);
        arb_won <= 1'b1;
        @(posedge aclk);
        k = 0;
        while (!sel_out && k < 40)
        begin
          @(posedge aclk);
          k++;
        end
        if (answer)
        begin
          repeat (lag) @(posedge aclk);
          target_bsy <= 1'b1;
          @(posedge aclk);
          for (i = 0; i < msg_n; i++) move_byte(3'h6);
          for (i = 0; i < cmd_n; i++) move_byte(3'h2);
          repeat (3) @(posedge aclk);
          if (!int_out)
          begin
            target_req <= 1'b1;
            bus_phase <= 3'h3;
            @(posedge aclk);
            target_req <= 1'b0;
            bus_phase <= 3'h4;
          end
        end
        k = 0;
        while (!int_out && k < 5000)
        begin
          @(posedge aclk);
          k++;
        end
        arb_won <= 1'b0;
        target_bsy <= 1'b0;
        @(posedge aclk);
      end
    end
  end
endmodule

// >>> tb/ssq_top_test.sv
`timescale 1ns/1ps
`include "ssq_cfg.svh"
module ssq_top_test;
  localparam int PU = 4;
  // Byte addresses, four times the register index
  localparam logic [7:0] a_tmo = 8'h14;
  localparam logic [7:0] a_step = 8'h18;
  localparam logic [7:0] a_clkf = 8'h24;
  localparam logic [7:0] a_cmd = 8'h40;
  localparam logic [7:0] a_len = 8'h44;
  localparam logic [7:0] a_bad = 8'h3c;
  logic aclk, aresetn, answer;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb, sync_offset_count, cmd_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, msg_n, lag;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic arb_won, target_bsy, target_req, byte_done;
  logic [2:0] bus_phase;
  logic arb_req, sel_out, atn_out, xfer_req, int_out;
  int failures, tests_run, tmo_v, clk_f, clen, n;

  ssq_top #(.PRESCALE_UNIT(PU)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .arb_won,
    .target_bsy, .target_req, .bus_phase, .byte_done, .sync_offset_count,
    .arb_req, .sel_out, .atn_out, .xfer_req, .int_out);
  ssq_far_end i_far (.aclk, .aresetn, .arb_req, .sel_out, .xfer_req,
    .int_out, .answer, .msg_n, .cmd_n, .lag, .arb_won, .target_bsy,
    .target_req, .bus_phase, .byte_done);

  // ----------------------------------------
  // Bench helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Write: both channels offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && k < 100);
    // A write that never answers counts against the run
    chk("bvalid", 1, s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && k < 100);
    // A read that never answers counts against the run
    chk("rvalid", 1, s_axi_rvalid);
    chk(nm, e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Counts selection cycles until the sequence reports
  task automatic wait_int(output int cnt);
    int k;
    cnt = 0;
    k = 0;
    while (!int_out && k < 3000)
    begin
      @(posedge aclk);
      k++;
      if (sel_out) cnt++;
    end
    @(posedge aclk);
  endtask

  task automatic hw_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    tmo_v = 0;
    clk_f = 2;
    clen = 6;
  endtask

  // One selection against the reference decode of step, cause, attention
  task automatic run(input int kind, input logic ans, input int mn,
                     input int cn);
    int need, est, eca, eatn, cnt, due, esof;
    n = rnd();
    answer <= ans;
    msg_n <= mn[1:0];
    cmd_n <= cn[3:0];
    lag <= 2'(rnd() % 3);
    sync_offset_count <= n[0] ? 4'hf : n[4:1];
    esof = (n[0] || n[4:1] == 4'hf) ? 0 : 8;
    need = kind == 2 ? 3 : (kind == 0 ? 0 : 1);
    eca = `SSQ_CAUSE_DONE;
    eatn = kind != 0;
    if (!ans)
    begin
      est = 0;
      eca = `SSQ_CAUSE_DISC;
      eatn = 0;
    end
    else if (mn < need || kind == 3)
      est = mn ? 2 : 0;
    else
    begin
      eatn = 0;
      est = cn >= clen ? 4 : (cn ? 3 : 2);
    end
    due = (tmo_v ? tmo_v : 1) * PU * (clk_f ? clk_f : 1);
    axw(a_cmd, kind, `SSQ_OKAY);
    wait_int(cnt);
    if (!ans) chk("timeout", 1, cnt >= due - 1 && cnt <= due + 2);
    chk("attention", eatn, atn_out);
    chk("interrupt", 1, int_out);
    // Every halt or completion leaves select, transfer and arbitrate released
    chk("select", 0, sel_out);
    chk("transfer", 0, xfer_req);
    chk("arbitrate", 0, arb_req);
    // Command readback: idle, attention as left, kind as started
    rchk("command", a_cmd, eatn * 4 + kind, `SSQ_OKAY);
    rchk("step", a_step, est | esof, `SSQ_OKAY);
    rchk("cause", a_tmo, eca, `SSQ_OKAY);
    chk("interrupt", 0, int_out);
    rchk("step", a_step, esof, `SSQ_OKAY);
  endtask

  // ----------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    test_done();
  end

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, answer, msg_n, cmd_n, lag} = '0;
    s_axi_wstrb = 4'hf;
    sync_offset_count = 4'h0;
    aresetn = 1'b0;
    failures = 0;
    tests_run = 0;
    seed = 32'h87231f13;
    hw_reset();
    rchk("clock factor", a_clkf, `SSQ_RST_CLKF, `SSQ_OKAY);
    rchk("length", a_len, `SSQ_RST_CMDLEN, `SSQ_OKAY);
    rchk("step", a_step, 32'h8, `SSQ_OKAY);
    rchk("cause", a_tmo, 32'h0, `SSQ_OKAY);
    rchk("unmapped", a_bad, 32'h0, `SSQ_SLVERR);
    axw(a_bad, 32'h5a, `SSQ_SLVERR);
    run(0, 1'b0, 0, 0);
    clk_f = 3;
    axw(a_clkf, 32'h3, `SSQ_OKAY);
    rchk("clock factor", a_clkf, 32'h3, `SSQ_OKAY);
    // Short value so the run stays brief instead of the standard span
    tmo_v = 1 + rnd() % 3;
    axw(a_tmo, tmo_v, `SSQ_OKAY);
    for (int k = 0; k < 4; k++) run(k, 1'b0, 0, 0);
    run(0, 1'b1, 0, 6);
    run(1, 1'b1, 1, 6);
    run(2, 1'b1, 3, 6);
    run(3, 1'b1, 1, 0);
    run(0, 1'b1, 0, 1 + rnd() % 5);
    run(0, 1'b1, 0, 0);
    run(1, 1'b1, 1, 1 + rnd() % 5);
    run(2, 1'b1, 3, 1 + rnd() % 5);
    run(1, 1'b1, 1, 0);
    run(1, 1'b1, 0, 0);
    run(2, 1'b1, 1 + rnd() % 2, 0);
    run(2, 1'b1, 0, 0);
    run(3, 1'b1, 0, 0);
    clen = 3;
    axw(a_len, 32'h3, `SSQ_OKAY);
    run(0, 1'b1, 0, 3);
    // Soft reset with a halted sequence still pending
    answer <= 1'b1;
    msg_n <= 2'h0;
    cmd_n <= 4'h0;
    sync_offset_count <= 4'h0;
    axw(a_cmd, 32'h0, `SSQ_OKAY);
    wait_int(n);
    axw(a_cmd, 32'h80, `SSQ_OKAY);
    chk("interrupt", 0, int_out);
    rchk("step", a_step, 32'h8, `SSQ_OKAY);
    run(1, 1'b0, 0, 0);
    hw_reset();
    run(0, 1'b0, 0, 0);
    test_done();
  end
endmodule
